//--- rtl/dri_addr_step.sv
// Address stepper: next address for fixed, incrementing or decrementing mode
`timescale 1ns/1ps
module dri_addr_step (
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  size,
  output logic [31:0]      nxt
);
  import dri_pkg::*;

  logic [31:0] unit;

  assign unit = dri_pkg::STEP_UNIT << size;

  always_comb begin
    case (mode)
      AM_INC:  nxt = addr + unit;
      AM_DEC:  nxt = addr - unit;
      default: nxt = addr;
    endcase
  end
endmodule // dri_addr_step

//--- rtl/dri_chan.sv
// DMA channel with address reload and indirect addressing, AHB-Lite registers
`timescale 1ns/1ps
// Notes on behaviour
// - Reload restores source address every four transfers
// - Burst mode keeps bus between transfers up to a reload point or zero count
// - Reload stops channel after fourth, releases bus
// - Without reload point, burst mode continues, keeps bus, steps source; cycle steal releases bus
// - Destination keeps stepping across reload points
// - Reload point clears request flag; otherwise untouched except at zero count
// - End interrupt at zero count if enabled
// - Zero count always clears request flag
// - Indirect: read pointer, read data, write destination
// - Pointer read is always a longword
// - Indirect source steps by longword per mode
// - Indirect write equals ordinary dual-address write
module dri_chan (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output dri_pkg::dri_mreq_s     mem_req,
  input  wire dri_pkg::dri_mrsp_s mem_rsp,
  output logic                   bus_req,
  input  wire logic              bus_grant,
  input  wire logic              dreq,
  output logic                   dreq_clr,
  output logic                   irq
);
  import dri_pkg::*;

  dri_state_s        s_r;
  dri_state_s        s_nxt;
  logic [31:0]       src_step;
  logic [31:0]       dst_step;
  logic [1:0]        src_size;
  logic [IRQ_W-1:0]  end_evt;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic              wr_stat;
  logic              wr_mask;
  logic [31:0]       rd_val;
  logic              in_step;
  logic              last_xfer;
  logic              reload_pt;

  // ------------------------------------------------------------
  // Address steppers and interrupt block
  // ------------------------------------------------------------
  assign src_size = s_r.ctrl.indirect ? SZ_LONG : s_r.ctrl.tsize;

  dri_addr_step u_src_step (
    .addr (s_r.src),
    .mode (s_r.ctrl.smode),
    .size (src_size),
    .nxt  (src_step)
  );

  dri_addr_step u_dst_step (
    .addr (s_r.dst),
    .mode (s_r.ctrl.dmode),
    .size (s_r.ctrl.tsize),
    .nxt  (dst_step)
  );

  dri_irq #(.W(IRQ_W)) u_irq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .evt     (end_evt),
    .wr_stat (wr_stat),
    .wr_mask (wr_mask),
    .wdata   (hwdata[IRQ_W-1:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (irq)
  );

  assign in_step   = (s_r.st == ST_STEP) && ce;
  assign last_xfer = (s_r.cnt == CNT_ONE);
  assign reload_pt = s_r.ctrl.reload && (s_r.grp == GRP_LAST);

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    case (haddr[OFS_W-1:0])
      OFS_SRC:  rd_val = s_r.src;
      OFS_DST:  rd_val = s_r.dst;
      OFS_CNT:  rd_val = s_r.cnt;
      OFS_CTRL: rd_val[CTRL_W-1:0] = s_r.ctrl;
      OFS_OPER: rd_val[OPER_EN_BIT] = s_r.oper;
      OFS_STAT: rd_val[IRQ_W-1:0] = irq_status;
      OFS_MASK: rd_val[IRQ_W-1:0] = irq_mask;
      default:  rd_val = '0;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  function automatic dri_mreq_s first_read(input dri_state_s s);
    dri_mreq_s m;
    m       = '0;
    m.valid = 1'b1;
    m.addr  = s.src;
    m.size  = s.ctrl.indirect ? SZ_LONG : s.ctrl.tsize;
    return m;
  endfunction

  always_comb begin
    s_nxt          = s_r;
    s_nxt.dreq_clr = 1'b0;
    end_evt        = '0;
    wr_stat        = 1'b0;
    wr_mask        = 1'b0;
    if (s_r.wpend) begin
      case (s_r.waddr)
        OFS_SRC: begin
          s_nxt.src      = hwdata;
          s_nxt.src_init = hwdata;
          s_nxt.grp      = GRP_FIRST;
        end
        OFS_DST: s_nxt.dst = hwdata;
        OFS_CNT: begin
          s_nxt.cnt = hwdata;
          s_nxt.grp = GRP_FIRST;
        end
        OFS_CTRL: s_nxt.ctrl = dri_ctrl_s'(hwdata[CTRL_W-1:0]);
        OFS_OPER: s_nxt.oper = hwdata[OPER_EN_BIT];
        OFS_STAT: wr_stat = 1'b1;
        OFS_MASK: wr_mask = 1'b1;
        default: ;
      endcase
    end
    s_nxt.wpend = hsel && hready && htrans[HTRANS_ACT_BIT] && hwrite;
    s_nxt.waddr = haddr[OFS_W-1:0];
    if (hsel && hready && htrans[HTRANS_ACT_BIT] && !hwrite) begin
      s_nxt.hrdata = rd_val;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.ctrl.en && s_r.oper && (s_r.cnt != CNT_ZERO) && dreq
            && !s_r.dreq_clr) begin
          s_nxt.bus_req = 1'b1;
          s_nxt.st      = ST_BUSREQ;
        end
      end
      ST_BUSREQ: begin
        if (bus_grant) begin
          s_nxt.mreq = first_read(s_r);
          s_nxt.st   = s_r.ctrl.indirect ? ST_PTR : ST_RD;
        end
      end
      ST_PTR: begin
        if (mem_rsp.ack) begin
          s_nxt.mreq.addr = mem_rsp.rdata;
          s_nxt.mreq.size = s_r.ctrl.tsize;
          s_nxt.st        = ST_RD;
        end
      end
      ST_RD: begin
        if (mem_rsp.ack) begin
          s_nxt.mreq.we    = 1'b1;
          s_nxt.mreq.addr  = s_r.dst;
          s_nxt.mreq.size  = s_r.ctrl.tsize;
          s_nxt.mreq.wdata = mem_rsp.rdata;
          s_nxt.st         = ST_WR;
        end
      end
      ST_WR: begin
        if (mem_rsp.ack) begin
          s_nxt.mreq = '0;
          s_nxt.st   = ST_STEP;
        end
      end
      ST_STEP: begin
        s_nxt.cnt = s_r.cnt - CNT_ONE;
        s_nxt.dst = dst_step;
        s_nxt.grp = s_r.grp + 2'h1;
        s_nxt.src = reload_pt ? s_r.src_init : src_step;
        s_nxt.dreq_clr = last_xfer || reload_pt;
        if (last_xfer) begin
          end_evt[IRQ_END] = s_r.ctrl.ie;
          s_nxt.bus_req    = 1'b0;
          s_nxt.grp        = GRP_FIRST;
          s_nxt.st         = ST_IDLE;
        end else if (reload_pt) begin
          s_nxt.bus_req = 1'b0;
          s_nxt.st      = ST_IDLE;
        end else if (s_r.ctrl.burst) begin
          s_nxt.src  = src_step;
          s_nxt.mreq = first_read(s_nxt);
          s_nxt.st   = s_r.ctrl.indirect ? ST_PTR : ST_RD;
        end else begin
          s_nxt.bus_req = 1'b0;
          s_nxt.st      = ST_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = s_r.hrdata;
  assign mem_req   = s_r.mreq;
  assign bus_req   = s_r.bus_req;
  assign dreq_clr  = s_r.dreq_clr;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_src_restore:
  assert property (in_step && reload_pt |=> s_r.src == $past(s_r.src_init))
    else $error("source address not restored at reload point");

  a_burst_hold:
  assert property (in_step && !last_xfer && !reload_pt && s_r.ctrl.burst
                   |=> bus_req && (s_r.st == ST_PTR || s_r.st == ST_RD))
    else $error("burst transfer gave up the bus");

  a_reload_release:
  assert property (in_step && reload_pt |=> !bus_req && s_r.st == ST_IDLE)
    else $error("bus kept after reload point");

  a_noreload_step:
  assert property (in_step && !s_r.ctrl.reload && s_r.ctrl.smode == AM_INC
                   && !s_r.ctrl.indirect |=> s_r.src == $past(src_step))
    else $error("source address did not step without reload");

  a_dst_step:
  assert property (in_step |=> s_r.dst == $past(dst_step))
    else $error("destination address did not step");

  a_clr_reload:
  assert property (in_step && !last_xfer |=> dreq_clr == $past(reload_pt))
    else $error("request flag clear wrong at group end");

  a_end_irq:
  assert property (in_step && last_xfer && s_r.ctrl.ie |=> irq_status[IRQ_END])
    else $error("end status not set at zero count");

  a_end_clr:
  assert property (in_step && last_xfer |=> dreq_clr ##1 !dreq_clr)
    else $error("request flag not cleared at zero count");

  a_ptr_long:
  assert property (s_r.st == ST_PTR |-> mem_req.valid && !mem_req.we
                   && mem_req.size == SZ_LONG)
    else $error("pointer read is not a longword");

  a_ind_src:
  assert property (in_step && s_r.ctrl.indirect && s_r.ctrl.smode == AM_INC && !reload_pt
                   |=> s_r.src == $past(s_r.src) + 32'h4)
    else $error("indirect source did not step by four");

  a_cnt_dec:
  assert property (in_step |=> s_r.cnt == $past(s_r.cnt) - CNT_ONE)
    else $error("transfer count did not decrement");

  a_clr_wait:
  assert property (dreq_clr |=> !bus_req)
    else $error("channel restarted on a cleared request");

  a_ptr_use:
  assert property (s_r.st == ST_PTR && mem_rsp.ack && ce
                   |=> mem_req.addr == $past(mem_rsp.rdata)
                   && mem_req.size == $past(s_r.ctrl.tsize))
    else $error("data read does not use the fetched pointer");

  c_reload_stop: cover property (in_step && reload_pt && !last_xfer);
  c_indirect_xfer: cover property (s_r.st == ST_PTR ##[1:20] s_r.st == ST_WR);
  c_end_irq: cover property (in_step && last_xfer ##1 irq);
  c_cycle_steal: cover property (in_step && !s_r.ctrl.burst && !last_xfer);
endmodule // dri_chan

//--- rtl/dri_irq.sv
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module dri_irq #(
  parameter int unsigned W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] evt,
  input  wire logic         wr_stat,
  input  wire logic         wr_mask,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      status,
  output logic [W-1:0]      mask,
  output logic              irq
);
  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
  } dri_irq_state_s;

  dri_irq_state_s s_r;
  dri_irq_state_s s_nxt;

  // ------------------------------------------------------------
  // Set wins over a clear in the same cycle
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (wr_stat) begin
      s_nxt.status = s_r.status & ~wdata;
    end
    s_nxt.status = s_nxt.status | evt;
    if (wr_mask) begin
      s_nxt.mask = wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign status = s_r.status;
  assign mask   = s_r.mask;
  assign irq    = |(s_r.status & s_r.mask);
endmodule // dri_irq

//--- rtl/dri_pkg.sv
// Package of constants and types for the reload and indirect address DMA channel
package dri_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned OFS_W    = 8;
  localparam logic [7:0]  OFS_SRC  = 8'h00;
  localparam logic [7:0]  OFS_DST  = 8'h04;
  localparam logic [7:0]  OFS_CNT  = 8'h08;
  localparam logic [7:0]  OFS_CTRL = 8'h0c;
  localparam logic [7:0]  OFS_OPER = 8'h10;
  localparam logic [7:0]  OFS_STAT = 8'h14;
  localparam logic [7:0]  OFS_MASK = 8'h18;
  localparam int unsigned OPER_EN_BIT = 0;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0]  SZ_BYTE   = 2'h0;
  localparam logic [1:0]  SZ_HALF   = 2'h1;
  localparam logic [1:0]  SZ_LONG   = 2'h2;
  localparam logic [1:0]  AM_FIXED  = 2'h0;
  localparam logic [1:0]  AM_INC    = 2'h1;
  localparam logic [1:0]  AM_DEC    = 2'h2;
  localparam logic [1:0]  GRP_FIRST = 2'h0;
  localparam logic [1:0]  GRP_LAST  = 2'h3;
  localparam logic [31:0] CNT_ONE   = 32'h0000_0001;
  localparam logic [31:0] CNT_ZERO  = 32'h0000_0000;
  localparam logic [31:0] STEP_UNIT = 32'h0000_0001;
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;
  localparam int unsigned IRQ_W   = 1;
  localparam int unsigned IRQ_END = 0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       indirect;
    logic       reload;
    logic       burst;
    logic [1:0] tsize;
    logic [1:0] dmode;
    logic [1:0] smode;
    logic       ie;
    logic       en;
  } dri_ctrl_s;
  localparam int unsigned CTRL_W = $bits(dri_ctrl_s);

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dri_mreq_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
  } dri_mrsp_s;

  typedef enum logic [2:0] {ST_IDLE, ST_BUSREQ, ST_PTR, ST_RD, ST_WR, ST_STEP} dri_st_e;

  typedef struct packed {
    dri_st_e     st;
    logic [31:0] src;
    logic [31:0] src_init;
    logic [31:0] dst;
    logic [31:0] cnt;
    dri_ctrl_s   ctrl;
    logic        oper;
    logic [1:0]  grp;
    dri_mreq_s   mreq;
    logic        bus_req;
    logic        dreq_clr;
    logic        wpend;
    logic [7:0]  waddr;
    logic [31:0] hrdata;
  } dri_state_s;

endpackage

//--- verif/dri_chan_tb.sv
// Self-checking testbench of the reload and indirect address DMA channel
`timescale 1ns/1ps
module dri_chan_tb;
  import dri_pkg::*;
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, bus_req, bus_grant;
  logic        dreq, dreq_clr, irq, br_q, rl, ind, bu, ie, mk;
  logic [1:0]  htrans, ts, sm, dm;
  logic [31:0] haddr, hwdata, hrdata, r, s_x, d_x, sa, da;
  dri_mreq_s   mem_req;
  dri_mrsp_s   mem_rsp;
  logic [66:0] expq[$];
  int          miscompares, compares, falls, clrs, n, seed;
  // ------------------------------------------------------------
  // Design and partner
  // ------------------------------------------------------------
  dri_chan uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .bus_req(bus_req), .bus_grant(bus_grant), .dreq(dreq),
    .dreq_clr(dreq_clr), .irq(irq)
  );
  dri_mem_model partner (
    .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .bus_req(bus_req), .bus_grant(bus_grant), .dreq_clr(dreq_clr), .dreq(dreq)
  );
  always #12.5 hclk = ~hclk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [34:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy(output logic [31:0] rd);
    logic rdy;
    rdy = 1'b0;
    for (int k = 0; k < 16 && !rdy; k++) begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end
    if (rdy !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy(rd);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(rd);
  endtask
  function automatic logic [31:0] memf(input logic [31:0] a);
    return {a[15:0] ^ 16'h00c3, a[31:16]};
  endfunction
  function automatic logic [31:0] stepf(input logic [31:0] a, input logic [1:0] m, sz);
    return (m == AM_INC) ? a + (32'h1 << sz) : (m == AM_DEC) ? a - (32'h1 << sz) : a;
  endfunction
  // ------------------------------------------------------------
  // Reference model of one programmed run
  // ------------------------------------------------------------
  task automatic build(input logic [31:0] s0, d0);
    logic [31:0] s, p;
    s = s0;
    d_x = d0;
    for (int i = 0; i < n; i++) begin
      p = s;
      if (ind) begin
        expq.push_back({1'b0, SZ_LONG, s, 32'h0});
        p = memf(s);
      end
      expq.push_back({1'b0, ts, p, 32'h0});
      expq.push_back({1'b1, ts, d_x, memf(p)});
      d_x = stepf(d_x, dm, ts);
      s = (rl && i % 4 == 3) ? s0 : stepf(s, sm, ind ? SZ_LONG : ts);
    end
    s_x = s;
  endtask
  // ------------------------------------------------------------
  // Memory traffic monitor
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    logic [66:0] e;
    logic [31:0] m;
    if (dreq_clr === 1'b1) clrs++;
    if (br_q === 1'b1 && bus_req === 1'b0) falls++;
    br_q = bus_req;
    if (mem_req.valid === 1'b1 && mem_rsp.ack === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : '1;
      m = (e[64:63] == SZ_BYTE) ? 32'hff : (e[64:63] == SZ_HALF) ? 32'hffff : '1;
      chk({mem_req.we, mem_req.size, mem_req.addr}, e[66:32]);
      if (e[66]) chk({3'h0, mem_req.wdata & m}, {3'h0, e[31:0] & m});
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = '0;
    hwdata = '0;
    miscompares = 0;
    compares = 0;
    seed = $urandom(32'h683a);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFS_CTRL, '0, r);
    chk({3'h0, r}, '0);
    ahb(1'b1, 8'h1c, 32'h5a, r);
    ahb(1'b0, 8'h1c, '0, r);
    chk({3'h0, r}, '0);
    ce <= 1'b0;
    ahb(1'b1, OFS_DST, 32'h5a, r);
    ce <= 1'b1;
    ahb(1'b0, OFS_DST, '0, r);
    chk({3'h0, r}, '0);
    for (int t = 0; t < 8; t++) begin
      rl = t[0];
      ind = t[1];
      bu = t[2] | rl;
      mk = ~t[0] | t[2];
      ie = 1'($urandom % 2);
      ts = 2'($urandom % 3);
      sm = 2'($urandom % 3);
      dm = 2'($urandom % 3);
      n = 4 * (1 + $urandom % 3);
      sa = $urandom & 32'h00ff_fff0;
      da = $urandom & 32'h00ff_fff0;
      build(sa, da);
      falls = 0;
      clrs = 0;
      ahb(1'b1, OFS_SRC, sa, r);
      ahb(1'b1, OFS_DST, da, r);
      ahb(1'b1, OFS_CTRL, {21'h0, ind, rl, bu, ts, dm, sm, ie, 1'b1}, r);
      ahb(1'b1, OFS_MASK, {31'h0, mk}, r);
      ahb(1'b1, OFS_OPER, 32'h1, r);
      ahb(1'b1, OFS_CNT, 32'(n), r);
      for (int k = 0; k < 3000 && (expq.size() > 0 || bus_req !== 1'b0); k++) @(posedge hclk);
      if (expq.size() > 0 || bus_req !== 1'b0) begin
        miscompares++;
        final_report();
      end
      repeat (3) @(posedge hclk);
      ahb(1'b0, OFS_SRC, '0, r);
      chk({3'h0, r}, {3'h0, s_x});
      ahb(1'b0, OFS_DST, '0, r);
      chk({3'h0, r}, {3'h0, d_x});
      ahb(1'b0, OFS_CNT, '0, r);
      chk({3'h0, r}, '0);
      ahb(1'b0, OFS_STAT, '0, r);
      chk({3'h0, r}, {34'h0, ie});
      chk({34'h0, irq}, {34'h0, ie & mk});
      chk(35'(falls), rl ? 35'(n / 4) : bu ? 35'h1 : 35'(n));
      chk(35'(clrs), rl ? 35'(n / 4) : 35'h1);
      ahb(1'b1, OFS_STAT, 32'h1, r);
      ahb(1'b0, OFS_STAT, '0, r);
      chk({3'h0, r}, '0);
      chk({34'h0, irq}, '0);
      $display("test %0d done", t);
    end
    final_report();
  end
endmodule // dri_chan_tb

//--- verif/dri_mem_model.sv
// Memory, bus arbiter and peripheral request flag facing the DMA channel
`timescale 1ns/1ps
module dri_mem_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire dri_pkg::dri_mreq_s mem_req,
  output dri_pkg::dri_mrsp_s      mem_rsp,
  input  wire logic               bus_req,
  output logic                    bus_grant,
  input  wire logic               dreq_clr,
  output logic                    dreq
);
  import dri_pkg::*;
  logic [1:0] wait_r;
  logic [2:0] idle_r;
  // ------------------------------------------------------------
  // Memory contents derived from the address
  // ------------------------------------------------------------
  function automatic logic [31:0] mem_f(input logic [31:0] a);
    return {a[15:0] ^ 16'h00c3, a[31:16]};
  endfunction
  // ------------------------------------------------------------
  // Random answer delay, released data toggles, flag rearms
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_rsp   <= '0;
      wait_r    <= 2'h0;
      idle_r    <= 3'h0;
      bus_grant <= 1'b0;
      dreq      <= 1'b0;
    end else begin
      bus_grant <= bus_req;
      if (!mem_rsp.ack && mem_req.valid && wait_r == 2'h0) begin
        mem_rsp.ack   <= 1'b1;
        mem_rsp.rdata <= mem_f(mem_req.addr);
        wait_r        <= 2'($urandom % 4);
      end else begin
        mem_rsp.ack   <= 1'b0;
        mem_rsp.rdata <= ~mem_rsp.rdata;
        if (!mem_rsp.ack && mem_req.valid) begin
          wait_r <= wait_r - 2'h1;
        end
      end
      if (dreq_clr) begin
        dreq   <= 1'b0;
        idle_r <= 3'h4;
      end else if (!dreq) begin
        if (idle_r == 3'h0) begin
          dreq <= 1'b1;
        end else begin
          idle_r <= idle_r - 3'h1;
        end
      end
    end
  end
endmodule // dri_mem_model
